/* hdl/dcos_scaler.sv */
// current output scaler: per-channel clamp and linear map with axi4-lite settings
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dcos_scaler (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [dcos_pkg::NUM_SRC*16-1:0] meas_value,
   input wire logic [dcos_pkg::NUM_SRC-1:0] meas_is_pf,
   output logic [dcos_pkg::NUM_CH*16-1:0] drive_current
);
   import dcos_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // settings and results

   logic signed [15:0] lower_drive_limit [NUM_CH];
   logic signed [15:0] upper_drive_limit [NUM_CH];
   logic [SRC_W-1:0] drive_value_select [NUM_CH];
   logic [1:0] current_span_select [NUM_CH];
   logic signed [15:0] out_current [NUM_CH];
   logic inhibited [NUM_CH];
   logic pf_active [NUM_CH];
   logic signed [15:0] next_lower [NUM_CH];
   logic signed [15:0] next_upper [NUM_CH];
   logic [SRC_W-1:0] next_select [NUM_CH];
   logic [1:0] next_span [NUM_CH];
   logic signed [15:0] next_out [NUM_CH];
   logic next_inhibited [NUM_CH];
   logic next_pf_active [NUM_CH];

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_out
         assign drive_current[g*16 +: 16] = out_current[g];
      end
   endgenerate

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave

   logic aw_held, w_held, next_aw_held, next_w_held;
   logic [7:0] waddr, next_waddr;
   logic [31:0] wdata, next_wdata;
   logic [3:0] wstrb, next_wstrb;
   logic [1:0] next_bresp, next_rresp;
   logic next_bvalid, next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0] wch, rch;
   logic [3:0] wofs, rofs;
   logic wmapped, rmapped;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wch = waddr[5:4];
   assign wofs = waddr[3:0];
   assign rch = s_axi_araddr[5:4];
   assign rofs = s_axi_araddr[3:0];
   assign wmapped = (waddr < 8'(NUM_CH) * CH_STRIDE) && (wofs != OFS_STATUS) && (wofs[1:0] == 2'h0);
   assign rmapped = (s_axi_araddr < 8'(NUM_CH) * CH_STRIDE) && (rofs[1:0] == 2'h0);

   ////////////////////////////////////////////////////////////////////////////
   // scaling engine, one channel at a time

   typedef enum logic [2:0] {
      DCOS_LOAD = 3'b001,
      DCOS_DIV = 3'b010,
      DCOS_STORE = 3'b100
   } dcos_state_t;

   dcos_state_t state, next_state;
   logic [1:0] ch, next_ch;
   logic signed [15:0] imin, next_imin;
   logic div_start, div_done;
   logic [31:0] div_numer, div_quot;
   logic [16:0] div_denom;
   logic signed [15:0] sel_x, sel_min, sel_max;
   logic signed [16:0] x_ext, lo_ext, hi_ext, gap, offset;
   logic [15:0] span_diff;
   logic sel_pf;

   always_comb begin
      // the channel's selection picks which measurement drives it
      sel_x = meas_value[drive_value_select[ch]*16 +: 16];
      sel_pf = meas_is_pf[drive_value_select[ch]];
      // span endpoints per channel; the unused code behaves as 0..1 mA
      case (current_span_select[ch])
         DCOS_SPAN_PM1: begin
            sel_min = I_PM1_MIN;
            sel_max = I_PM1_MAX;
         end
         DCOS_SPAN_4_20: begin
            sel_min = I_4_20_MIN;
            sel_max = I_4_20_MAX;
         end
         default: begin
            sel_min = I_0_1_MIN;
            sel_max = I_0_1_MAX;
         end
      endcase
      // power factor uses its natural -1..+1 pu range instead of the limits
      // limits and measurements share the q3.12 per-unit base
      lo_ext = sel_pf ? -17'(PU_ONE) : 17'(lower_drive_limit[ch]);
      hi_ext = sel_pf ? 17'(PU_ONE) : 17'(upper_drive_limit[ch]);
      x_ext = 17'(sel_x);
      gap = hi_ext - lo_ext;
      offset = x_ext - lo_ext;
      span_diff = 16'(sel_max - sel_min);
      // the product stays below 2^31: offset under 2^16, span under 2^15
      div_numer = 32'(offset[16:0]) * 32'(span_diff);
      div_denom = gap;
   end

   always_comb begin
      next_state = state;
      next_ch = ch;
      next_imin = imin;
      div_start = 1'b0;
      next_out = out_current;
      next_inhibited = inhibited;
      next_pf_active = pf_active;
      case (state)
         DCOS_LOAD: begin
            next_imin = sel_min;
            next_pf_active[ch] = sel_pf;
            next_inhibited[ch] = 1'b0;
            next_ch = ch + 2'h1;
            if (!sel_pf && gap < MIN_LIMIT_GAP) begin
               next_inhibited[ch] = 1'b1;
               next_out[ch] = sel_min;
            end else if (x_ext < lo_ext) begin
               next_out[ch] = sel_min;
            end else if (x_ext > hi_ext) begin
               next_out[ch] = sel_max;
            end else begin
               div_start = 1'b1;
               next_ch = ch;
               next_state = DCOS_DIV;
            end
         end
         DCOS_DIV: begin
            if (div_done) begin
               next_state = DCOS_STORE;
            end
         end
         DCOS_STORE: begin
            // quotient never exceeds the span difference since x is within limits
            next_out[ch] = imin + 16'(div_quot[15:0]);
            next_ch = ch + 2'h1;
            next_state = DCOS_LOAD;
         end
         default: begin
            next_state = DCOS_LOAD;
         end
      endcase
   end

   dcos_divider u_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(div_start),
      .numer(div_numer),
      .denom(div_denom),
      .done(div_done),
      .quot(div_quot)
   );

   ////////////////////////////////////////////////////////////////////////////
   // register bus next state

   always_comb begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_waddr = waddr;
      next_wdata = wdata;
      next_wstrb = wstrb;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      next_rvalid = s_axi_rvalid;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      next_lower = lower_drive_limit;
      next_upper = upper_drive_limit;
      next_select = drive_value_select;
      next_span = current_span_select;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_waddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_wdata = s_axi_wdata;
         next_wstrb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      // address and data may arrive in either order; commit once both are held
      if (aw_held && w_held) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = wmapped ? RESP_OKAY : RESP_SLVERR;
         if (wmapped) begin
            case (wofs)
               OFS_LOWER: next_lower[wch] = merge16(lower_drive_limit[wch], wdata, wstrb);
               OFS_UPPER: next_upper[wch] = merge16(upper_drive_limit[wch], wdata, wstrb);
               default: begin
                  if (wstrb[0]) begin
                     next_select[wch] = wdata[CFG_SRC_LSB +: SRC_W];
                     next_span[wch] = wdata[CFG_SPAN_LSB +: 2];
                  end
               end
            endcase
         end
      end
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp = rmapped ? RESP_OKAY : RESP_SLVERR;
         next_rdata = 32'h00000000;
         if (rmapped) begin
            case (rofs)
               OFS_LOWER: next_rdata = 32'(unsigned'(lower_drive_limit[rch]));
               OFS_UPPER: next_rdata = 32'(unsigned'(upper_drive_limit[rch]));
               OFS_CONFIG: begin
                  next_rdata[CFG_SRC_LSB +: SRC_W] = drive_value_select[rch];
                  next_rdata[CFG_SPAN_LSB +: 2] = current_span_select[rch];
               end
               default: begin
                  next_rdata[15:0] = out_current[rch];
                  next_rdata[STS_INHIBIT_BIT] = inhibited[rch];
                  next_rdata[STS_PF_BIT] = pf_active[rch];
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         waddr <= 8'h00;
         wdata <= 32'h00000000;
         wstrb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OKAY;
         state <= DCOS_LOAD;
         ch <= 2'h0;
         imin <= 16'sh0000;
         for (int i = 0; i < NUM_CH; i++) begin
            lower_drive_limit[i] <= RST_LOWER;
            upper_drive_limit[i] <= RST_UPPER;
            drive_value_select[i] <= RST_SRC;
            current_span_select[i] <= RST_SPAN;
            out_current[i] <= I_4_20_MIN;
            inhibited[i] <= 1'b0;
            pf_active[i] <= 1'b0;
         end
      end else begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         waddr <= next_waddr;
         wdata <= next_wdata;
         wstrb <= next_wstrb;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
         state <= next_state;
         ch <= next_ch;
         imin <= next_imin;
         lower_drive_limit <= next_lower;
         upper_drive_limit <= next_upper;
         drive_value_select <= next_select;
         current_span_select <= next_span;
         out_current <= next_out;
         inhibited <= next_inhibited;
         pf_active <= next_pf_active;
      end
   end
endmodule
`default_nettype wire

/* hdl/dcos_pkg.sv */
// constants shared by the current output scaler
// How it works
// - drive value below lower limit commands the span minimum current.
// - drive value above upper limit commands the span maximum current.
// - in between, minimum plus span difference times offset over limit difference.
// - output inhibited when upper minus lower limit is under 0.1 pu.
// - power-factor sources ignore the programmed limits on that channel.
// - each channel picks -1..1 mA, 4..20 mA or 0..1 mA on its own.
// - each channel is driven by the measured quantity its selection names.
// - limits are per-unit numbers on the same base as the measurements.
package dcos_pkg;
   localparam int NUM_CH = 4;
   localparam int NUM_SRC = 8;
   localparam int SRC_W = 3;
   // per-unit values are signed q3.12: 1 pu = 0x1000
   localparam logic signed [15:0] PU_ONE = 16'sh1000;
   localparam logic signed [16:0] MIN_LIMIT_GAP = 17'sh0019a;
   // currents in microamps, signed
   typedef enum logic [1:0] {
      DCOS_SPAN_PM1 = 2'h0,
      DCOS_SPAN_4_20 = 2'h1,
      DCOS_SPAN_0_1 = 2'h2
   } dcos_span_t;
   localparam logic signed [15:0] I_PM1_MIN = -16'sh03e8;
   localparam logic signed [15:0] I_PM1_MAX = 16'sh03e8;
   localparam logic signed [15:0] I_4_20_MIN = 16'sh0fa0;
   localparam logic signed [15:0] I_4_20_MAX = 16'sh4e20;
   localparam logic signed [15:0] I_0_1_MIN = 16'sh0000;
   localparam logic signed [15:0] I_0_1_MAX = 16'sh03e8;
   localparam int DIV_STEPS = 32;
   // register map: one 16-byte block per channel
   localparam logic [7:0] CH_STRIDE = 8'h10;
   localparam logic [3:0] OFS_LOWER = 4'h0;
   localparam logic [3:0] OFS_UPPER = 4'h4;
   localparam logic [3:0] OFS_CONFIG = 4'h8;
   localparam logic [3:0] OFS_STATUS = 4'hc;
   localparam int CFG_SRC_LSB = 0;
   localparam int CFG_SPAN_LSB = 4;
   localparam int STS_INHIBIT_BIT = 16;
   localparam int STS_PF_BIT = 17;
   localparam logic signed [15:0] RST_LOWER = 16'sh0000;
   localparam logic signed [15:0] RST_UPPER = 16'sh1000;
   localparam logic [SRC_W-1:0] RST_SRC = 3'h0;
   localparam logic [1:0] RST_SPAN = 2'h1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* hdl/dcos_divider.sv */
// unsigned restoring divider, one quotient bit per clock
`timescale 1ns/1ps
`default_nettype none
module dcos_divider (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic start,
   input wire logic [31:0] numer,
   input wire logic [16:0] denom,
   output logic done,
   output logic [31:0] quot
);
   import dcos_pkg::*;
   logic [5:0] count, next_count;
   logic [17:0] rem, next_rem;
   logic [31:0] next_quot;
   logic [16:0] den, next_den;
   logic busy, next_busy, next_done;
   logic [17:0] shifted;

   always_comb begin
      next_count = count;
      next_rem = rem;
      next_quot = quot;
      next_den = den;
      next_busy = busy;
      next_done = 1'b0;
      shifted = {rem[16:0], quot[31]};
      if (start) begin
         next_busy = 1'b1;
         next_count = 6'h00;
         next_rem = 18'h00000;
         next_quot = numer;
         next_den = denom;
      end else if (busy) begin
         // quotient bits shift in where numerator bits shift out
         if (shifted >= {1'b0, den}) begin
            next_rem = shifted - {1'b0, den};
            next_quot = {quot[30:0], 1'b1};
         end else begin
            next_rem = shifted;
            next_quot = {quot[30:0], 1'b0};
         end
         next_count = count + 6'h01;
         if (count == 6'(DIV_STEPS - 1)) begin
            next_busy = 1'b0;
            next_done = 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= 6'h00;
         rem <= 18'h00000;
         quot <= 32'h00000000;
         den <= 17'h00000;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         count <= next_count;
         rem <= next_rem;
         quot <= next_quot;
         den <= next_den;
         busy <= next_busy;
         done <= next_done;
      end
   end
endmodule
`default_nettype wire

/* verif/dcos_scaler_asserts.sv */
// port checker for the current output scaler
`timescale 1ns/1ps
`default_nettype none
module dcos_scaler_asserts (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [dcos_pkg::NUM_SRC*16-1:0] meas_value,
   input wire logic [dcos_pkg::NUM_SRC-1:0] meas_is_pf,
   input wire logic [dcos_pkg::NUM_CH*16-1:0] drive_current
);
   import dcos_pkg::*;
   logic [7:0] quiet;
   logic in_span;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////////////////
   // cycles since a measurement input moved; a write commits late, so awvalid also clears it
   always_ff @(posedge aclk) begin
      if (!aresetn || $changed(meas_value) || $changed(meas_is_pf) || s_axi_awvalid) begin
         quiet <= 8'h00;
      end else if (quiet != 8'hff) begin
         quiet <= quiet + 8'h01;
      end
   end
   always_comb begin
      in_span = 1'b1;
      for (int c = 0; c < NUM_CH; c++) begin
         if ($signed(drive_current[16*c +: 16]) < I_PM1_MIN || $signed(drive_current[16*c +: 16]) > I_4_20_MAX) begin
            in_span = 1'b0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   AST_IN_SPAN: assert property (in_span)
      else $error("drive current outside all spans");
   // a stale divide plus a full round of linear channels can take about 175 cycles
   AST_SETTLED: assert property (quiet > 8'hc0 |-> $stable(drive_current))
      else $error("drive current moved with steady inputs");
   AST_RST_SPAN: assert property ($rose(aresetn) |-> drive_current == {NUM_CH{I_4_20_MIN}})
      else $error("drive current not at span minimum after reset");
   AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp}))
      else $error("read data dropped");
   COV_SLVERR: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_SLVERR);
   COV_READ: cover property (s_axi_rvalid && s_axi_rready);
   COV_DRIVE: cover property (!$stable(drive_current));
endmodule
`default_nettype wire

/* verif/dcos_loop_rx.sv */
// model of the loop receivers fed by the output channels
`timescale 1ns/1ps
`default_nettype none
module dcos_loop_rx (
   input wire logic aclk,
   input wire logic [dcos_pkg::NUM_CH*16-1:0] drive_current,
   output logic [dcos_pkg::NUM_CH*16-1:0] loop_ua
);
   import dcos_pkg::*;
   ////////////////////////////////////////////////////////////////////////////////
   // the receiver sees the loop one cycle late, like a slow converter stage
   always_ff @(posedge aclk) begin
      loop_ua <= drive_current;
   end
endmodule
`default_nettype wire

/* verif/dc_current_output_scaler_test.sv */
// self-checking bench for the current output scaler
`timescale 1ns/1ps
`default_nettype none
module dc_current_output_scaler_test;
   import dcos_pkg::*;
   logic aclk, aresetn;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [NUM_SRC*16-1:0] meas_value;
   logic [NUM_SRC-1:0] meas_is_pf;
   logic [NUM_CH*16-1:0] drive_current, loop_ua;
   int err_count, comparisons, cycles;
   dcos_scaler dut (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .meas_value(meas_value),
      .meas_is_pf(meas_is_pf),
      .drive_current(drive_current)
   );
   dcos_loop_rx rx (.aclk(aclk), .drive_current(drive_current), .loop_ua(loop_ua));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk({30'h0, s_axi_bresp}, {30'h0, er});
      // one idle edge so a following call never re-raises bready in the same step
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, ed);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
      @(posedge aclk);
   endtask
   // a stale divide plus one full round can delay a change by about 175 cycles
   task automatic cur(input int c, input logic [15:0] e);
      repeat (200) @(posedge aclk);
      chk({16'h0, loop_ua[16*c +: 16]}, {16'h0, e});
   endtask
   task report_and_stop;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 6000) begin
         err_count++;
         report_and_stop();
      end
   end
   initial begin
      aresetn = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      meas_value = '0;
      meas_is_pf = 8'h00;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int c = 0; c < NUM_CH; c++) cur(c, I_4_20_MIN);
      rd(8'h08, 32'h10, RESP_OKAY);
      rd(8'h04, {16'h0, RST_UPPER}, RESP_OKAY);
      // source 5 is never selected, so its large value must not leak out
      meas_value <= {16'h0, 16'h0, 16'h7000, 16'h0080, 16'h0800, 16'hff00, 16'h2000, 16'h0800};
      meas_is_pf <= 8'h08;
      wr(8'h08, 32'h0, RESP_OKAY);
      wr(8'h18, 32'h11, RESP_OKAY);
      wr(8'h28, 32'h22, RESP_OKAY);
      wr(8'h34, 32'h199, RESP_OKAY);
      wr(8'h38, 32'h14, RESP_OKAY);
      cur(0, 16'h0000);
      cur(1, I_4_20_MAX);
      cur(2, I_0_1_MIN);
      cur(3, I_4_20_MIN);
      rd(8'h3c, 32'h00010fa0, RESP_OKAY);
      wr(8'h34, 32'h19a, RESP_OKAY);
      cur(3, 16'h2323);
      rd(8'h34, 32'h19a, RESP_OKAY);
      meas_value[31:16] <= 16'h0400;
      cur(1, 16'h1f40);
      wr(8'h08, 32'h03, RESP_OKAY);
      cur(0, 16'h01f4);
      wr(8'h0c, 32'h0, RESP_SLVERR);
      rd(8'h0c, 32'h000201f4, RESP_OKAY);
      rd(8'h40, 32'h0, RESP_SLVERR);
      // only byte lane 1 enabled: the low byte of the limit must keep its old value
      s_axi_wstrb <= 4'h2;
      wr(8'h00, 32'h000012ab, RESP_OKAY);
      rd(8'h00, 32'h00001200, RESP_OKAY);
      report_and_stop();
   end
endmodule
bind dcos_scaler dcos_scaler_asserts u_asserts (
   .aclk(aclk),
   .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready),
   .meas_value(meas_value),
   .meas_is_pf(meas_is_pf),
   .drive_current(drive_current)
);
`default_nettype wire
